// ---- hdl/sbs_map.svh ----
// Purpose: Constants for the serdes byte sync, wrap and clocking block
// Assumes: One core clock at 125 MHz; each core cycle stands for one serial bit time
// Notes:   Definitions only
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// ****************************************
// Word layout
// ****************************************
`define SBS_WORD_W        10
`define SBS_BIT_CNT_W     4
`define SBS_LAST_BIT      4'h9
`define SBS_REF_MULT      10

// ****************************************
// Comma pattern 0011111XXX, first received bit leftmost
// ****************************************
`define SBS_COMMA_LEN     7
`define SBS_COMMA_BITS    7'h1f

// ****************************************
// Values shown on the parallel side
// ****************************************
`define SBS_RX_LOS_WORD   10'h3ff
`define SBS_TX_IDLE_WORD  10'h3ff
`define SBS_RX_RESET_WORD 10'h3ff

// ****************************************
// Clock figures in kHz
// ****************************************
`define SBS_REF_FC_KHZ    106250
`define SBS_REF_GE_KHZ    125000
`define SBS_CORE_KHZ      125000
`define SBS_RXCLK_DIV     2

`endif

// ---- hdl/sbs_pkg.sv ----
// Purpose: Types for the serdes byte sync, wrap and clocking block
// Assumes: Used through explicit package scoping only
// Notes:   Numbers live in sbs_map.svh
package sbs_pkg;

  typedef enum logic [1:0] {
    SBS_RX_NO_LINE = 2'b00,
    SBS_RX_HUNT    = 2'b01,
    SBS_RX_FRAMED  = 2'b10
  } sbs_rx_state_t;

endpackage

// ---- hdl/sbs_buf2.sv ----
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Same clock on both sides
// Notes:   Full and empty are exact; ready drops when both entries hold words
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_buf2 (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  input  wire logic [`SBS_WORD_W-1:0]   i_in_word,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  output logic      [`SBS_WORD_W-1:0]   o_out_word,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready
);

  logic [`SBS_WORD_W-1:0] mem_q [2];
  logic [`SBS_WORD_W-1:0] mem_d [2];
  logic                   wr_q, wr_d;
  logic                   rd_q, rd_d;
  logic [1:0]             cnt_q, cnt_d;
  logic                   push, pop;

  always_comb begin
    push     = i_in_valid && (cnt_q != 2'h2);
    pop      = (cnt_q != 2'h0) && i_out_ready;
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (push) begin
      mem_d[wr_q] = i_in_word;
    end
    wr_d  = push ? ~wr_q : wr_q;
    rd_d  = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mem_q[0] <= `SBS_TX_IDLE_WORD;
      mem_q[1] <= `SBS_TX_IDLE_WORD;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      cnt_q    <= cnt_d;
    end
  end

  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_word  = mem_q[rd_q];

endmodule
`default_nettype wire

// ---- hdl/sbs_tx_ser.sv ----
// Purpose: Word-rate divider and 10-bit serializer
// Assumes: One core cycle per serial bit
// Notes:   Sends the idle word when no host word is waiting at a word boundary
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_tx_ser (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  input  wire logic [`SBS_WORD_W-1:0]   i_word,
  input  wire logic                     i_valid,
  output logic                          o_ready,
  output logic                          o_bit,
  output logic                          o_word_tick
);

  logic [`SBS_BIT_CNT_W-1:0] cnt_q, cnt_d;
  logic [`SBS_WORD_W-1:0]    sh_q, sh_d;

  // Ten bit times per word: the bit rate is ten times the word rate
  always_comb begin
    o_word_tick = (cnt_q == `SBS_LAST_BIT);
    cnt_d       = o_word_tick ? '0 : cnt_q + `SBS_BIT_CNT_W'(1);
    if (o_word_tick) begin
      sh_d = i_valid ? i_word : `SBS_TX_IDLE_WORD;
    end else begin
      sh_d = {1'b1, sh_q[`SBS_WORD_W-1:1]};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
      sh_q  <= `SBS_TX_IDLE_WORD;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  assign o_ready = o_word_tick;
  assign o_bit   = sh_q[0];

endmodule
`default_nettype wire

// ---- hdl/sbs_top.sv ----
// Purpose: Parallel-side control of a 10-bit serdes: comma alignment, serial wrap, receive word clocks
// Assumes: i_core_clk is the reference/transmit word clock domain, one cycle per serial bit time
// Notes:   Serial and control pins are resynchronised; analog PLL and line levels are outside
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_top (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  input  wire logic [`SBS_WORD_W-1:0]   i_tx_word,
  input  wire logic                     i_tx_valid,
  output logic                          o_tx_ready,
  input  wire logic                     i_serial_in,
  input  wire logic                     i_line_present,
  input  wire logic                     i_serial_wrap_enable,
  input  wire logic                     i_comma_align_enable,
  output logic                          o_serial_out,
  output logic      [`SBS_WORD_W-1:0]   o_rx_word,
  output logic                          o_rx_word_clock_a,
  output logic                          o_rx_word_clock_b,
  output logic                          o_comma_detect_flag,
  output logic                          o_line_presence_flag
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit 0 serial in, 1 line present, 2 wrap enable, 3 align enable
  localparam int unsigned NPIN = 4;

  logic [NPIN-1:0] s1_q, s1_d;
  logic [NPIN-1:0] s2_q, s2_d;
  logic [NPIN-1:0] s3_q, s3_d;
  logic [NPIN-1:0] pin_q, pin_d;

  always_comb begin
    s1_d = {i_comma_align_enable, i_serial_wrap_enable, i_line_present, i_serial_in};
    s2_d = s1_q;
    s3_d = s2_q;
    // Serial bits change every bit time, so the agree filter would swallow lone bits
    pin_d[0] = s3_q[0];
    // A control change is taken only once the last two stages agree
    for (int i = 1; i < NPIN; i++) begin
      pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      pin_q <= pin_d;
    end
  end

  logic ext_bit;
  logic line_ok;
  logic wrap_en;
  logic align_en;

  assign ext_bit  = pin_q[0];
  assign line_ok  = pin_q[1];
  assign wrap_en  = pin_q[2];
  assign align_en = pin_q[3];

  // ****************************************
  // Transmit path
  // ****************************************
  logic [`SBS_WORD_W-1:0] buf_word;
  logic                   buf_valid;
  logic                   ser_ready;
  logic                   ser_bit;
  logic                   word_tick;
  logic                   tx_in_ready;

  // Two entries absorb a word offered while the serializer is mid-word
  sbs_buf2 u_buf (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_word   (i_tx_word),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (tx_in_ready),
    .o_out_word  (buf_word),
    .o_out_valid (buf_valid),
    .i_out_ready (ser_ready)
  );

  // Bit 0 of each word leaves first
  sbs_tx_ser u_ser (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_word      (buf_word),
    .i_valid     (buf_valid),
    .o_ready     (ser_ready),
    .o_bit       (ser_bit),
    .o_word_tick (word_tick)
  );

  logic tx_ready_q, tx_ready_d;
  logic sout_q, sout_d;

  always_comb begin
    tx_ready_d = tx_in_ready;
    sout_d     = wrap_en ? 1'b1 : ser_bit;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_ready_q <= 1'b0;
      sout_q     <= 1'b1;
    end else begin
      tx_ready_q <= tx_ready_d;
      sout_q     <= sout_d;
    end
  end

  // ****************************************
  // Receive framing
  // ****************************************
  function automatic logic sbs_is_comma(input logic [`SBS_WORD_W-1:0] w);
    logic [`SBS_COMMA_LEN-1:0] lead;
    // Bit 0 is the first arrival and maps to the leftmost pattern bit
    for (int i = 0; i < `SBS_COMMA_LEN; i++) begin
      lead[`SBS_COMMA_LEN-1-i] = w[i];
    end
    return lead == `SBS_COMMA_BITS;
  endfunction

  sbs_pkg::sbs_rx_state_t    st_q, st_d;
  logic [`SBS_WORD_W-1:0]    sh_q, sh_d;
  logic [`SBS_BIT_CNT_W-1:0] bcnt_q, bcnt_d;
  logic                      rx_bit;
  logic                      comma_hit;
  logic                      word_done;

  always_comb begin
    // Wrap takes the transmit stream before the output blanking
    rx_bit    = wrap_en ? ser_bit : ext_bit;
    // Newest bit enters at the top, so bit 0 is the oldest of the ten
    sh_d      = {rx_bit, sh_q[`SBS_WORD_W-1:1]};
    comma_hit = align_en && sbs_is_comma(sh_d);
    word_done = 1'b0;
    bcnt_d    = bcnt_q;
    st_d      = st_q;
    unique case (st_q)
      sbs_pkg::SBS_RX_NO_LINE: begin
        bcnt_d = '0;
        if (line_ok) begin
          st_d = sbs_pkg::SBS_RX_HUNT;
        end
      end
      sbs_pkg::SBS_RX_HUNT,
      sbs_pkg::SBS_RX_FRAMED: begin
        if (!line_ok) begin
          st_d = sbs_pkg::SBS_RX_NO_LINE;
        end else if (comma_hit) begin
          // Reframe: this bit closes the comma word
          word_done = 1'b1;
          bcnt_d    = '0;
          st_d      = sbs_pkg::SBS_RX_FRAMED;
        end else if (bcnt_q == `SBS_LAST_BIT) begin
          word_done = 1'b1;
          bcnt_d    = '0;
        end else begin
          bcnt_d = bcnt_q + `SBS_BIT_CNT_W'(1);
        end
      end
      default: begin
        st_d   = sbs_pkg::SBS_RX_NO_LINE;
        bcnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q   <= sbs_pkg::SBS_RX_NO_LINE;
      sh_q   <= `SBS_RX_RESET_WORD;
      bcnt_q <= '0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      bcnt_q <= bcnt_d;
    end
  end

  // ****************************************
  // Receive word outputs and word clocks
  // ****************************************
  logic [`SBS_WORD_W-1:0] rxw_q, rxw_d;
  logic                   clk_b_q, clk_b_d;
  logic                   clk_a_q, clk_a_d;
  logic                   cdet_q, cdet_d;
  logic                   lpf_q, lpf_d;

  always_comb begin
    rxw_d   = rxw_q;
    clk_b_d = clk_b_q;
    cdet_d  = 1'b0;
    lpf_d   = line_ok;
    if (!line_ok || st_q == sbs_pkg::SBS_RX_NO_LINE) begin
      rxw_d = `SBS_RX_LOS_WORD;
    end else if (word_done) begin
      rxw_d  = sh_d;
      // Each word flips both clocks except a comma word, which sets b high; rising edges alternate a, b, a
      clk_b_d = comma_hit ? 1'b1 : ~clk_b_q;
      // Flag only rises under alignment enable
      cdet_d  = comma_hit;
    end
    // One flip per word gives half the word rate on each clock
    clk_a_d = ~clk_b_d;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rxw_q   <= `SBS_RX_RESET_WORD;
      clk_b_q <= 1'b0;
      clk_a_q <= 1'b1;
      cdet_q  <= 1'b0;
      lpf_q   <= 1'b0;
    end else begin
      rxw_q   <= rxw_d;
      clk_b_q <= clk_b_d;
      clk_a_q <= clk_a_d;
      cdet_q  <= cdet_d;
      lpf_q   <= lpf_d;
    end
  end

  // ****************************************
  // Outputs, all from flip-flops
  // ****************************************
  // The receiver counts on the same core clock as the transmitter
  assign o_tx_ready           = tx_ready_q;
  assign o_serial_out         = sout_q;
  assign o_rx_word            = rxw_q;
  assign o_rx_word_clock_a    = clk_a_q;
  assign o_rx_word_clock_b    = clk_b_q;
  assign o_comma_detect_flag  = cdet_q;
  assign o_line_presence_flag = lpf_q;

endmodule
`default_nettype wire

// ---- dv/sbs_top_monitor.sv ----
// Purpose: Port-level checker for sbs_top
// Assumes: One core clock, synchronous active-high reset
// Notes:   Pins pass a sync chain, so pin-driven checks wait 8 cycles
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_top_monitor (
  input wire logic                   i_core_clk,
  input wire logic                   i_reset,
  input wire logic [`SBS_WORD_W-1:0] i_tx_word,
  input wire logic                   i_tx_valid,
  input wire logic                   o_tx_ready,
  input wire logic                   i_serial_in,
  input wire logic                   i_line_present,
  input wire logic                   i_serial_wrap_enable,
  input wire logic                   i_comma_align_enable,
  input wire logic                   o_serial_out,
  input wire logic [`SBS_WORD_W-1:0] o_rx_word,
  input wire logic                   o_rx_word_clock_a,
  input wire logic                   o_rx_word_clock_b,
  input wire logic                   o_comma_detect_flag,
  input wire logic                   o_line_presence_flag
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  comma_shape_a: assert property (o_comma_detect_flag |-> {o_rx_word[0], o_rx_word[1], o_rx_word[2], o_rx_word[3], o_rx_word[4], o_rx_word[5], o_rx_word[6]} == `SBS_COMMA_BITS)
    else $error("flag without comma word");
  comma_clock_a: assert property (o_comma_detect_flag |-> o_rx_word_clock_b && !o_rx_word_clock_a)
    else $error("comma word not on clock b");
  clocks_anti_a: assert property (o_rx_word_clock_a != o_rx_word_clock_b)
    else $error("word clocks not complementary");
  flag_pulse_a: assert property (o_comma_detect_flag |=> !o_comma_detect_flag)
    else $error("comma flag longer than one cycle");
  wrap_quiet_a: assert property (i_serial_wrap_enable [*8] |-> o_serial_out)
    else $error("serial out not held high in wrap");
  line_lost_a: assert property (!i_line_present [*8] |-> !o_line_presence_flag && o_rx_word == `SBS_RX_LOS_WORD)
    else $error("lost line not shown");
  align_off_a: assert property (!i_comma_align_enable [*8] |-> !o_comma_detect_flag)
    else $error("comma flag while alignment off");
  clock_hold_a: assert property ($rose(o_rx_word_clock_a) |=> ($stable(o_rx_word_clock_a) || o_comma_detect_flag) [*8])
    else $error("word clock a toggled early");

  cover property (o_comma_detect_flag);
  cover property ($rose(o_rx_word_clock_a));
  cover property (i_serial_wrap_enable && o_serial_out);
  cover property (i_tx_valid && !o_tx_ready);
endmodule

bind sbs_top sbs_top_monitor u_mon (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_tx_word(i_tx_word), .i_tx_valid(i_tx_valid),
  .o_tx_ready(o_tx_ready), .i_serial_in(i_serial_in), .i_line_present(i_line_present),
  .i_serial_wrap_enable(i_serial_wrap_enable), .i_comma_align_enable(i_comma_align_enable),
  .o_serial_out(o_serial_out), .o_rx_word(o_rx_word), .o_rx_word_clock_a(o_rx_word_clock_a),
  .o_rx_word_clock_b(o_rx_word_clock_b), .o_comma_detect_flag(o_comma_detect_flag),
  .o_line_presence_flag(o_line_presence_flag));
`default_nettype wire

// ---- dv/sbs_host_model.sv ----
// Purpose: Host controller on the 10-bit parallel side
// Assumes: Words are already line coded by the caller
// Notes:   Waits one idle edge after each take, since ready lags a cycle
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module sbs_host_model (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_tx_ready,
  input  wire logic [`SBS_WORD_W-1:0] i_rx_word,
  input  wire logic                   i_rx_word_clock_a,
  input  wire logic                   i_rx_word_clock_b,
  output logic      [`SBS_WORD_W-1:0] o_tx_word,
  output logic                        o_tx_valid
);
  logic                   saw_full = 1'b0;
  logic [`SBS_WORD_W-1:0] got_q [$];

  initial begin
    o_tx_word  = `SBS_TX_IDLE_WORD;
    o_tx_valid = 1'b0;
  end

  // Capture on both word clocks
  always @(posedge i_rx_word_clock_a or posedge i_rx_word_clock_b) begin
    // Let the word settle after the clock edge that launches it
    #1;
    got_q.push_back(i_rx_word);
  end

  task automatic send(input logic [`SBS_WORD_W-1:0] w);
    int n;
    n = 0;
    @(negedge i_core_clk);
    o_tx_word  = w;
    o_tx_valid = 1'b1;
    @(posedge i_core_clk);
    while (i_tx_ready !== 1'b1 && n < 100) begin
      saw_full = 1'b1;
      n++;
      @(posedge i_core_clk);
    end
    @(negedge i_core_clk);
    o_tx_valid = 1'b0;
    // Released word shows garbage, not the last value
    o_tx_word  = ~w;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for sbs_top
// Assumes: 125 MHz core clock, one cycle per serial bit
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.svh"

module tb_top;
  localparam logic [9:0] comma_word = 10'h17c;
  localparam logic [9:0] data_word  = 10'h2a5;
  logic       i_core_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_serial_in = 1'b1;
  logic       i_line_present = 1'b0;
  logic       i_serial_wrap_enable = 1'b0;
  logic       i_comma_align_enable = 1'b0;
  logic [9:0] tx_word, rx_word;
  logic       tx_valid, tx_ready, serial_out, clk_a, clk_b, flag, present;
  int         fail_count = 0;
  int         tests_run = 0;

  always #4 i_core_clk = ~i_core_clk;

  sbs_top DUT (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_tx_word(tx_word), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_serial_in(i_serial_in), .i_line_present(i_line_present),
    .i_serial_wrap_enable(i_serial_wrap_enable), .i_comma_align_enable(i_comma_align_enable),
    .o_serial_out(serial_out), .o_rx_word(rx_word), .o_rx_word_clock_a(clk_a), .o_rx_word_clock_b(clk_b),
    .o_comma_detect_flag(flag), .o_line_presence_flag(present));
  sbs_host_model HOST (.i_core_clk(i_core_clk), .i_tx_ready(tx_ready), .i_rx_word(rx_word),
    .i_rx_word_clock_a(clk_a), .i_rx_word_clock_b(clk_b), .o_tx_word(tx_word), .o_tx_valid(tx_valid));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Counts: %0d compared, %0d bad", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic send_bits(input logic [9:0] w);
    for (int i = 0; i < 10; i++) begin
      @(negedge i_core_clk);
      i_serial_in = w[i];
    end
  endtask

  task automatic stream();
    cycles(12);
    send_bits(comma_word);
    send_bits(data_word);
    @(negedge i_core_clk);
    i_serial_in = 1'b1;
  endtask

  // Flag wait is bounded; a miss shows up as a failed compare
  task automatic expect_pair(input string what);
    bit hit;
    hit = 1'b0;
    for (int n = 0; n < 120 && !hit; n++) begin
      @(negedge i_core_clk);
      hit = (flag === 1'b1);
    end
    check({9'h0, hit}, 10'h001, what);
    check(rx_word, comma_word, what);
    check({9'h0, clk_b}, 10'h001, what);
    cycles(10);
    check(rx_word, data_word, what);
    check({8'h0, clk_a, flag}, 10'h002, what);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_line();
    check({tx_ready, serial_out, clk_a, clk_b, flag, present, 4'h0}, 10'h180, "reset values");
    check(rx_word, `SBS_RX_RESET_WORD, "reset word");
    @(negedge i_core_clk);
    i_reset = 1'b0;
    cycles(12);
    check({present, rx_word[8:0]}, 10'h1ff, "no line");
    i_line_present = 1'b1;
    cycles(8);
    check({9'h0, present}, 10'h001, "line seen");
    $display("test reset_and_line done");
  endtask

  task automatic t_rx_external();
    i_comma_align_enable = 1'b1;
    cycles(8);
    fork
      stream();
      expect_pair("external comma");
    join
    $display("test rx_external done");
  endtask

  task automatic t_align_off();
    int flags;
    flags = 0;
    i_comma_align_enable = 1'b0;
    cycles(8);
    fork
      stream();
      repeat (50) begin
        @(negedge i_core_clk);
        if (flag !== 1'b0) flags++;
      end
    join
    check(10'(flags), 10'h000, "flag while disabled");
    $display("test align_off done");
  endtask

  task automatic t_wrap();
    int zeros;
    bit got;
    zeros = 0;
    got = 1'b0;
    i_serial_wrap_enable = 1'b1;
    i_comma_align_enable = 1'b1;
    cycles(8);
    HOST.got_q.delete();
    fork
      begin
        HOST.send(comma_word);
        HOST.send(data_word);
      end
      expect_pair("wrapped comma");
      repeat (60) begin
        @(negedge i_core_clk);
        // Toggling outside input must be ignored in wrap
        i_serial_in = ~i_serial_in;
        if (serial_out !== 1'b1) zeros++;
      end
    join
    i_serial_in = 1'b1;
    foreach (HOST.got_q[i]) if (HOST.got_q[i] === data_word) got = 1'b1;
    check(10'(zeros), 10'h000, "serial out in wrap");
    check({9'h0, got}, 10'h001, "host capture");
    $display("test wrap done");
  endtask

  task automatic t_tx_stream();
    logic [39:0] exp;
    logic [39:0] got;
    int n;
    exp = {10'h355, 10'h0f0, data_word, comma_word};
    n = 0;
    i_serial_wrap_enable = 1'b0;
    cycles(8);
    HOST.saw_full = 1'b0;
    fork
      for (int k = 0; k < 4; k++) HOST.send(exp[k*10 +: 10]);
      begin
        while (serial_out !== 1'b0 && n < 80) begin
          @(negedge i_core_clk);
          n++;
        end
        for (int i = 0; i < 40; i++) begin
          got[i] = serial_out;
          @(negedge i_core_clk);
        end
      end
    join
    for (int k = 0; k < 4; k++) check(got[k*10 +: 10], exp[k*10 +: 10], "serial order");
    check({9'h0, HOST.saw_full}, 10'h001, "buffer refusal");
    i_line_present = 1'b0;
    cycles(12);
    check({present, rx_word[8:0]}, 10'h1ff, "line lost");
    $display("test tx_stream done");
  endtask

  initial begin
    cycles(1);
    t_reset_and_line();
    t_rx_external();
    t_align_off();
    t_wrap();
    t_tx_stream();
    summarize();
  end

  initial begin
    #100000;
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
